// [rcg_pkg.sv]
// package for the reset and clock gating block
`default_nettype none
package rcg_pkg;
  // software reset bit location in processor mode register 0
  localparam logic [7:0] PM0_ADDR = 8'h5E;
  localparam int SWRST_BIT = 3;
  // reset vector locations
  localparam logic [15:0] RST_VEC_LO = 16'hFFFE;
  localparam logic [15:0] RST_VEC_HI = 16'hFFFF;
  // reset output low time in half cycles of the output clock (4.5 cycles)
  localparam int RSTOUT_HALF_CYCLES = 9;
  // post-reset internal sequence length in clk cycles
  localparam int POST_SEQ_CYCLES = 8;
  localparam int DIV_BITS = 9;
  localparam logic [3:0] CNT_ZERO4 = 4'h0;
  localparam logic [DIV_BITS-1:0] DIV_ZERO = 9'h000;

  typedef struct packed {
    logic stop_instruction;
    logic wait_instruction;
    logic ready_accepted;
    logic busreq_accepted;
    logic cpu_wait_req;
  } rcg_gate_req_t;

  typedef struct packed {
    logic bus_interface_unit_en;
    logic cpu_en;
    logic ext_clk_en;
  } rcg_clk_en_t;
endpackage
`default_nettype wire

// [rcg_reset_clock.sv]
// reset sequencing, clock enables and peripheral dividers
`default_nettype none
// Functional notes
// - A write of one to bit 3 at address 5E starts a software reset equal to a hardware reset.
// - Software reset leaves internal RAM untouched while all other state is reinitialised; the peripheral dividers and output clock here keep running.
// - After reset the post-reset sequence runs and execution starts from the vector at FFFE/FFFF.
// - On software reset the reset output pin goes low for 4.5 cycles of the output clock.
// - The bus interface unit clock stops on ready, stop or wait, and runs during bus requests.
// - The CPU clock stops on stop, wait, ready acceptance, bus request acceptance and a CPU wait request.
// - The output clock matches the bus interface unit clock period and stops only on stop.
// - Divided peripheral clocks from divide-by-2 to divide-by-512 are provided.
module rcg_reset_clock (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire rcg_pkg::rcg_gate_req_t gate_req,
  output logic reset_output_pin_n,
  output logic core_rst,
  output logic ram_rst,
  output logic post_seq_active,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic ext_clk_out,
  output var rcg_pkg::rcg_clk_en_t clk_en,
  output logic [rcg_pkg::DIV_BITS-1:0] peripheral_divided_clocks
);
  // ==================================================
  // reset pin synchroniser
  logic pin_s1_r, pin_s2_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end
  // pulse length on the pin is the board's duty
  wire hw_rst = !pin_s2_r;

  // ==================================================
  // software reset sequencer
  typedef enum logic [1:0] {ST_RUN, ST_SWRST, ST_POST} rcg_state_t;
  rcg_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  wire sw_rst_req = sfr_wr && (sfr_addr == rcg_pkg::PM0_ADDR)
    && sfr_wdata[rcg_pkg::SWRST_BIT];
  wire rstout_done = (cnt_r == 4'(rcg_pkg::RSTOUT_HALF_CYCLES - 1));
  wire post_done = (cnt_r == 4'(rcg_pkg::POST_SEQ_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 4'h1;
    unique case (state_r)
      ST_RUN: begin
        cnt_nxt = rcg_pkg::CNT_ZERO4;
        if (sw_rst_req) begin
          state_nxt = ST_SWRST;
        end
      end
      ST_SWRST: begin
        if (rstout_done) begin
          state_nxt = ST_POST;
          cnt_nxt = rcg_pkg::CNT_ZERO4;
        end
      end
      ST_POST: begin
        if (post_done) begin
          state_nxt = ST_RUN;
          cnt_nxt = rcg_pkg::CNT_ZERO4;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_POST;
      cnt_r <= rcg_pkg::CNT_ZERO4;
    end else if (hw_rst) begin
      state_r <= ST_POST;
      cnt_r <= rcg_pkg::CNT_ZERO4;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==================================================
  // reset outputs and vector fetch
  logic rstout_n_r, core_rst_r, vec_r;
  logic [15:0] vaddr_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstout_n_r <= 1'b1;
      core_rst_r <= 1'b1;
      vec_r <= 1'b0;
      vaddr_r <= rcg_pkg::RST_VEC_LO;
    end else begin
      rstout_n_r <= (state_nxt != ST_SWRST) || hw_rst;
      core_rst_r <= hw_rst || (state_nxt == ST_SWRST);
      vec_r <= (state_r == ST_POST) && post_done && !hw_rst;
      vaddr_r <= (state_r == ST_POST && cnt_r[0]) ? rcg_pkg::RST_VEC_HI : rcg_pkg::RST_VEC_LO;
    end
  end
  assign reset_output_pin_n = rstout_n_r;
  assign core_rst = core_rst_r;
  assign ram_rst = 1'b0;
  assign post_seq_active = (state_r == ST_POST);
  assign vector_fetch = vec_r;
  assign vector_addr = vaddr_r;

  // ==================================================
  // clock enables and output clock
  wire stop_req = gate_req.stop_instruction;
  wire wait_req = gate_req.wait_instruction;
  wire bus_clk_run = !(stop_req || wait_req || gate_req.ready_accepted);
  wire cpu_run = bus_clk_run && !gate_req.cpu_wait_req && !gate_req.busreq_accepted;
  wire ext_run = !stop_req;
  logic [2:0] en_r;
  logic ext_clk_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 3'h0;
      ext_clk_r <= 1'b0;
    end else begin
      en_r <= {bus_clk_run, cpu_run, ext_run};
      ext_clk_r <= ext_run ? !ext_clk_r : ext_clk_r;
    end
  end
  assign clk_en = rcg_pkg::rcg_clk_en_t'(en_r);
  assign ext_clk_out = ext_clk_r;

  // ==================================================
  // peripheral dividers, halted in stop mode
  logic [rcg_pkg::DIV_BITS-1:0] div_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= rcg_pkg::DIV_ZERO;
    end else if (ext_run) begin
      div_r <= div_r + 9'h001;
    end
  end
  assign peripheral_divided_clocks = div_r;

  // ==================================================
  // checks
  a_swrst_pin_low: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RUN && sw_rst_req && !hw_rst) |=> !reset_output_pin_n [*8])
    else $error("reset output not held low");
  a_rstout_width: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RUN && sw_rst_req && !hw_rst) |=> !reset_output_pin_n [*8] ##1 !reset_output_pin_n ##1 reset_output_pin_n)
    else $error("reset output low time wrong");
  a_pin_idle_high: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RUN && !sw_rst_req) |=> reset_output_pin_n)
    else $error("reset output low without request");
  a_swrst_core: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RUN && sw_rst_req && !hw_rst) |=> core_rst)
    else $error("core reset missing on software reset");
  a_hw_core_rst: assert property (@(posedge clk) disable iff (sys_rst)
    hw_rst |=> core_rst)
    else $error("core reset missing on pin reset");
  a_ram_kept: assert property (@(posedge clk) disable iff (sys_rst)
    core_rst |-> !ram_rst)
    else $error("ram reset during reset");
  a_pin_returns: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_SWRST && rstout_done && !hw_rst) |=> reset_output_pin_n && post_seq_active)
    else $error("reset output did not return high");
  a_core_release: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_SWRST && rstout_done && !hw_rst) |=> !core_rst)
    else $error("core reset held after pulse");
  a_hw_restart: assert property (@(posedge clk) disable iff (sys_rst)
    hw_rst |=> post_seq_active && !vector_fetch)
    else $error("post sequence not restarted by pin reset");
  a_vector_fetch: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_POST && post_done && !hw_rst) |=> vector_fetch ##1 !vector_fetch)
    else $error("vector fetch missing");
  a_vector_pair: assert property (@(posedge clk) disable iff (sys_rst)
    vector_fetch |-> vector_addr == rcg_pkg::RST_VEC_HI && $past(vector_addr) == rcg_pkg::RST_VEC_LO)
    else $error("vector address order wrong");
  a_run_after_fetch: assert property (@(posedge clk) disable iff (sys_rst)
    vector_fetch |-> !post_seq_active && !core_rst)
    else $error("still in reset at vector fetch");
  a_bus_clk_run: assert property (@(posedge clk) disable iff (sys_rst)
    (gate_req.busreq_accepted && !stop_req && !wait_req && !gate_req.ready_accepted) |=> clk_en.bus_interface_unit_en)
    else $error("bus clock stopped by bus request");
  a_bus_clk_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_req || wait_req || gate_req.ready_accepted) |=> !clk_en.bus_interface_unit_en)
    else $error("bus clock not stopped");
  a_cpu_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (gate_req.cpu_wait_req || wait_req) |=> !clk_en.cpu_en)
    else $error("cpu clock not stopped");
  a_cpu_ready_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (gate_req.ready_accepted || gate_req.busreq_accepted || stop_req) |=> !clk_en.cpu_en)
    else $error("cpu clock ran on ready or bus request");
  a_ext_clk_stop: assert property (@(posedge clk) disable iff (sys_rst)
    stop_req |=> $stable(ext_clk_out))
    else $error("output clock ran in stop mode");
  a_ext_en_stop: assert property (@(posedge clk) disable iff (sys_rst)
    stop_req |=> !clk_en.ext_clk_en)
    else $error("output clock enable set in stop mode");
  a_ext_clk_run: assert property (@(posedge clk) disable iff (sys_rst)
    (!stop_req && wait_req) |=> (ext_clk_out != $past(ext_clk_out)))
    else $error("output clock stopped in wait");
  a_ext_clk_busy: assert property (@(posedge clk) disable iff (sys_rst)
    (!stop_req && (gate_req.ready_accepted || gate_req.busreq_accepted)) |=> (ext_clk_out != $past(ext_clk_out)))
    else $error("output clock stopped on ready or bus request");
  a_div_count: assert property (@(posedge clk) disable iff (sys_rst)
    !stop_req |=> peripheral_divided_clocks == $past(peripheral_divided_clocks) + 9'h001)
    else $error("divider did not advance");
  a_div_hold: assert property (@(posedge clk) disable iff (sys_rst)
    stop_req |=> $stable(peripheral_divided_clocks))
    else $error("divider ran in stop mode");
endmodule
`default_nettype wire

// [rcg_board_model.sv]
// external reset circuit model with oscillator settle delay
`default_nettype none
module rcg_board_model #(
  parameter int HOLD_CYC = 200,
  parameter int OSC_SETTLE = 50
) (
  input wire logic clk,
  input wire logic pulse_req,
  output logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // 200 cycles of 10 ns is the 2 us minimum
  initial begin
    reset_pin_n = 1'b0;
    repeat (OSC_SETTLE + HOLD_CYC) @(negedge clk);
    reset_pin_n = 1'b1;
    forever begin
      @(posedge pulse_req);
      @(negedge clk);
      reset_pin_n = 1'b0;
      repeat (HOLD_CYC) @(negedge clk);
      reset_pin_n = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [rcg_reset_clock_tb_top.sv]
// self-checking bench for the reset and clock gating block
`default_nettype none
module rcg_reset_clock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, pulse_req = 1'b0, reset_pin_n;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  rcg_pkg::rcg_gate_req_t gate_req = 5'h00;
  logic reset_output_pin_n, core_rst, ram_rst, post_seq_active, vector_fetch, ext_clk_out;
  logic [15:0] vector_addr;
  rcg_pkg::rcg_clk_en_t clk_en;
  logic [rcg_pkg::DIV_BITS-1:0] peripheral_divided_clocks;
  int mismatches = 0, checked = 0;
  // stable clock fed as on the oscillator input pin
  always #5 clk = ~clk;
  rcg_board_model rcg_board_model_inst (.clk(clk), .pulse_req(pulse_req), .reset_pin_n(reset_pin_n));
  rcg_reset_clock rcg_reset_clock_inst (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .gate_req(gate_req),
    .reset_output_pin_n(reset_output_pin_n), .core_rst(core_rst), .ram_rst(ram_rst),
    .post_seq_active(post_seq_active), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .ext_clk_out(ext_clk_out), .clk_en(clk_en), .peripheral_divided_clocks(peripheral_divided_clocks));
  // ==========================================
  // compare, fetch-wait and closing tasks
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_fetch(output int n);
    n = 0;
    while (vector_fetch !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask
  // ==========================================
  // scenarios
  task automatic test_boot();
    int n;
    wait_fetch(n);
    chk_bit(n < 600, 1'b1);
    chk_bit(vector_addr == 16'hFFFE || vector_addr == 16'hFFFF, 1'b1);
    chk_bit(reset_output_pin_n, 1'b1);
  endtask
  task automatic test_soft(input logic [7:0] addr, input logic [7:0] data, input logic hit);
    int n, k;
    @(negedge clk);
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    k = 0;
    while (reset_output_pin_n !== 1'b0 && k < 3) begin
      @(negedge clk);
      k++;
    end
    n = 0;
    while (reset_output_pin_n === 1'b0 && n < 40) begin
      chk_bit(core_rst, 1'b1);
      chk_bit(ram_rst, 1'b0);
      n++;
      @(negedge clk);
    end
    chk_word(16'(n), hit ? 16'h0009 : 16'h0000);
    if (hit) begin
      chk_bit(post_seq_active, 1'b1);
      wait_fetch(n);
      chk_word(16'(n), 16'(rcg_pkg::POST_SEQ_CYCLES));
    end
  endtask
  task automatic test_gating();
    logic [4:0] g;
    logic a, b;
    logic [8:0] d;
    for (int i = 0; i < 32; i++) begin
      g = 5'(i);
      @(negedge clk);
      gate_req = g;
      repeat (3) @(negedge clk);
      b = !(g[4] | g[3] | g[2]);
      chk_word(16'(clk_en), {13'h0000, b, b & !g[1] & !g[0], !g[4]});
      a = ext_clk_out;
      d = peripheral_divided_clocks;
      @(negedge clk);
      chk_bit(ext_clk_out !== a, !g[4]);
      chk_word(16'(peripheral_divided_clocks), 16'(g[4] ? d : 9'(d + 9'h001)));
    end
    gate_req = 5'h00;
  endtask
  task automatic test_pin_reset();
    int n;
    @(negedge clk);
    pulse_req = 1'b1;
    repeat (6) @(negedge clk);
    pulse_req = 1'b0;
    chk_bit(core_rst, 1'b1);
    wait_fetch(n);
    chk_bit(n < 600, 1'b1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    test_boot();
    test_soft(8'h5E, 8'h08, 1'b1);
    test_soft(8'h5E, 8'hF7, 1'b0);
    test_soft(8'h5D, 8'h08, 1'b0);
    test_gating();
    test_pin_reset();
    report_and_stop();
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
